// [hw/ccdrs_line_rebuild.sv]
// module: dual output line rebuild, right samples reversed after left
`timescale 1ns/1ps
`default_nettype none
module ccdrs_line_rebuild #(
    parameter int DW    = ccdrs_pkg::SAMPLE_W,
    parameter int HALF  = ccdrs_pkg::PIX_ACTIVE_D
) (
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst_b,
    // capture side
    input  wire logic              cap_en,
    input  wire logic [DW-1:0]     cap_left,
    input  wire logic [DW-1:0]     cap_right,
    input  wire logic              cap_last,
    // rebuilt output
    output logic                   out_valid,
    output logic [DW-1:0]          out_data,
    output logic                   out_last
);
    localparam int AW = $clog2(2*HALF);
    if (HALF < 2)
    begin : g_bad_half
        $error("HALF too small");
    end

    logic [DW-1:0] buf_q [0:2*HALF-1];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic          play_q;

    // ************
    // capture and playback
    // ************
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            wr_q      <= '0;
            rd_q      <= '0;
            play_q    <= 1'b0;
            out_valid <= 1'b0;
            out_last  <= 1'b0;
            out_data  <= '0;
        end
        else
        begin
            out_valid <= 1'b0;
            out_last  <= 1'b0;
            if (cap_en && !play_q)
            begin
                buf_q[wr_q]                    <= cap_left;
                buf_q[AW'(2*HALF-1) - wr_q]    <= cap_right;
                if (cap_last)
                begin
                    wr_q   <= '0;
                    play_q <= 1'b1;
                end
                else
                    wr_q <= wr_q + AW'(1);
            end
            if (play_q)
            begin
                out_valid <= 1'b1;
                out_data  <= buf_q[rd_q];
                if (rd_q == AW'(2*HALF-1))
                begin
                    out_last <= 1'b1;
                    rd_q     <= '0;
                    play_q   <= 1'b0;
                end
                else
                    rd_q <= rd_q + AW'(1);
            end
        end
    end
endmodule : ccdrs_line_rebuild
`default_nettype wire

// [hw/ccdrs_pkg.sv]
// package: constants for the image sensor readout sequencer
package ccdrs_pkg;
    // row structure of a frame, in order toward the horizontal register
    localparam int ROWS_DARK_LEAD   = 2;
    localparam int ROWS_ACTIVE      = 1208;
    localparam int ROWS_DARK_TRAIL  = 4;
    localparam int ROWS_BUFFER      = 4;
    localparam int ROWS_IMAGE       = 1200;
    localparam int ROWS_TOTAL       = ROWS_DARK_LEAD + ROWS_ACTIVE + ROWS_DARK_TRAIL;
    // pixel structure of one line
    localparam int PIX_EMPTY        = 4;
    localparam int PIX_DARK         = 16;
    localparam int PIX_ACTIVE_S     = 1608;
    localparam int PIX_ACTIVE_D     = 800;
    localparam int PIX_BUFFER       = 4;
    localparam int PIX_IMAGE_S      = 1600;
    localparam int PIX_LINE_S       = 1644;
    localparam int PIX_LINE_D       = 824;
    // vertical pulse, hold and horizontal half period timing in system clock cycles, then sample width
    localparam int VERT_PULSE_CYC   = 8;
    localparam int HOLD_DELAY_CYC   = 16;
    localparam int HALF_PERIOD_CYC  = 2;
    localparam int SAMPLE_W         = 14;
    // first and last image row, dark and buffer rows excluded
    localparam int ROW_IMAGE_FIRST    = ROWS_DARK_LEAD + ROWS_BUFFER;
    localparam int ROW_IMAGE_LAST     = ROW_IMAGE_FIRST + ROWS_IMAGE - 1;
    // first and last image column of a single output line
    localparam int COL_IMAGE_FIRST_S  = PIX_EMPTY + PIX_DARK + PIX_BUFFER;
    localparam int COL_IMAGE_LAST_S   = COL_IMAGE_FIRST_S + PIX_IMAGE_S - 1;
    // first and last photosensitive column of a dual output half-line
    localparam int COL_ACTIVE_FIRST_D = PIX_EMPTY + PIX_DARK;
    localparam int COL_ACTIVE_LAST_D  = COL_ACTIVE_FIRST_D + PIX_ACTIVE_D - 1;
endpackage : ccdrs_pkg

// [hw/ccdrs_timing_gen.sv]
// module: timing generator that drives the sensor's transfer clocks and captures video
// Functional notes
// - dual mode reverses right half clocking
// - right samples reversed then appended
// - hold horizontal a high, b low
// - wait hold delay after vertical fall
// - line dump high discards whole line
// - no vertical or dump pulses during shifting
// - single mode clocks 1644 pixels
// - dual mode clocks 824 pixels
`timescale 1ns/1ps
`default_nettype none
module ccdrs_timing_gen #(
    parameter int DW        = ccdrs_pkg::SAMPLE_W,
    parameter int VPULSE    = ccdrs_pkg::VERT_PULSE_CYC,
    parameter int HOLD      = ccdrs_pkg::HOLD_DELAY_CYC,
    parameter int HALFP     = ccdrs_pkg::HALF_PERIOD_CYC
) (
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst_b,
    // control
    input  wire logic              frame_start,
    input  wire logic              dual_mode,
    input  wire logic              skip_lines,
    // sensor clocks
    output logic                   vert_phase_a,
    output logic                   vert_phase_b,
    output logic                   horiz_phase_a,
    output logic                   horiz_phase_b,
    output logic                   right_reverse,
    output logic                   fast_line_dump,
    // converter samples
    input  wire logic [DW-1:0]     video_left,
    input  wire logic [DW-1:0]     video_right,
    // image stream
    output logic                   pix_valid,
    output logic [DW-1:0]          pix_data,
    output logic                   pix_line_end,
    output logic                   pix_frame_end,
    output logic                   busy
);
    // ************
    // types and parameter checks
    // ************
    typedef enum logic [2:0] {ST_IDLE, ST_VERT, ST_HOLD, ST_HORIZ, ST_DRAIN, ST_DONE} ccdrs_state_t;

    if (VPULSE < 1 || VPULSE > 65535 || HOLD < 1 || HOLD > 65535)
    begin : g_bad_timing
        $error("vertical pulse and hold counts must lie in 1 to 65535");
    end
    // capture sits late in the high half of a pixel, so that half needs two cycles
    if (HALFP < 2 || HALFP > 16383)
    begin : g_bad_half
        $error("horizontal half period must lie in 2 to 16383");
    end

    ccdrs_state_t  st_q;
    logic [10:0]   row_q;
    logic [10:0]   pix_q;
    logic [15:0]   cnt_q;
    logic          dual_q;
    logic          skip_q;
    logic          drained_q;
    logic          cap_en_q;
    logic          cap_last_q;
    logic          cap_frame_q;
    logic [DW-1:0] cap_left_q;
    logic [DW-1:0] cap_right_q;
    logic          rb_valid;
    logic [DW-1:0] rb_data;
    logic          rb_last;
    logic          dump_row;
    logic          last_row;
    logic          pix_wrap;
    logic          line_done;
    logic          h_low;
    logic [10:0]   line_last;
    logic [10:0]   col_last;

    // ************
    // decoding helpers
    // ************
    function automatic logic in_span(input logic [10:0] v, input int lo, input int hi);
        return (v >= 11'(lo)) && (v <= 11'(hi));
    endfunction : in_span

    function automatic logic row_is_image(input logic [10:0] r);
        return in_span(r, ccdrs_pkg::ROW_IMAGE_FIRST, ccdrs_pkg::ROW_IMAGE_LAST);
    endfunction : row_is_image

    function automatic logic col_is_kept(input logic [10:0] c, input logic dual);
        if (dual)
            return in_span(c, ccdrs_pkg::COL_ACTIVE_FIRST_D, ccdrs_pkg::COL_ACTIVE_LAST_D);
        return in_span(c, ccdrs_pkg::COL_IMAGE_FIRST_S, ccdrs_pkg::COL_IMAGE_LAST_S);
    endfunction : col_is_kept

    function automatic ccdrs_state_t after_row(input logic last);
        return last ? ST_DONE : ST_VERT;
    endfunction : after_row

    // frame ends after the trailing dark rows
    assign last_row  = (row_q == 11'(ccdrs_pkg::ROWS_TOTAL - 1));
    // non-image rows are dumped when skipping
    assign dump_row  = skip_q && !row_is_image(row_q);
    // last cycle of a pixel period, also the capture point
    assign pix_wrap  = (st_q == ST_HORIZ) && (cnt_q == 16'(2 * HALFP - 1));
    assign h_low     = (st_q == ST_HORIZ) && (cnt_q < 16'(HALFP));
    // horizontal clocks per line by mode
    assign line_last = dual_q ? 11'(ccdrs_pkg::PIX_LINE_D - 1)
                              : 11'(ccdrs_pkg::PIX_LINE_S - 1);
    assign line_done = pix_wrap && (pix_q == line_last);
    assign col_last  = dual_q ? 11'(ccdrs_pkg::COL_ACTIVE_LAST_D)
                              : 11'(ccdrs_pkg::COL_IMAGE_LAST_S);

    // ************
    // row and pixel sequencing
    // ************
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            st_q   <= ST_IDLE;
            row_q  <= '0;
            pix_q  <= '0;
            cnt_q  <= '0;
            dual_q <= 1'b0;
            skip_q <= 1'b0;
        end
        else
        begin
            case (st_q)
                ST_IDLE:
                begin
                    if (frame_start)
                    begin
                        st_q   <= ST_VERT;
                        row_q  <= '0;
                        cnt_q  <= '0;
                        dual_q <= dual_mode;
                        skip_q <= skip_lines;
                    end
                end
                ST_VERT:
                begin
                    if (cnt_q == 16'(VPULSE - 1))
                    begin
                        st_q  <= ST_HOLD;
                        cnt_q <= '0;
                    end
                    else
                        cnt_q <= cnt_q + 16'd1;
                end
                ST_HOLD:
                begin
                    if (cnt_q == 16'(HOLD - 1))
                    begin
                        cnt_q <= '0;
                        pix_q <= '0;
                        // a dumped line leaves the register empty, nothing to clock out
                        if (dump_row)
                        begin
                            st_q  <= after_row(last_row);
                            row_q <= row_q + 11'd1;
                        end
                        else
                            st_q <= ST_HORIZ;
                    end
                    else
                        cnt_q <= cnt_q + 16'd1;
                end
                ST_HORIZ:
                begin
                    if (pix_wrap)
                    begin
                        cnt_q <= '0;
                        pix_q <= pix_q + 11'd1;
                        if (line_done)
                        begin
                            if (dual_q && row_is_image(row_q))
                                st_q <= ST_DRAIN;
                            else
                            begin
                                st_q  <= after_row(last_row);
                                row_q <= row_q + 11'd1;
                            end
                        end
                    end
                    else
                        cnt_q <= cnt_q + 16'd1;
                end
                // next transfer waits for the rebuilt line
                ST_DRAIN:
                begin
                    if (drained_q)
                    begin
                        st_q  <= after_row(last_row);
                        row_q <= row_q + 11'd1;
                        cnt_q <= '0;
                    end
                end
                ST_DONE:
                    st_q <= ST_IDLE;
                default:
                    st_q <= ST_IDLE;
            endcase
        end
    end

    // ************
    // sensor clocks
    // ************
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            vert_phase_a   <= 1'b0;
            vert_phase_b   <= 1'b0;
            fast_line_dump <= 1'b0;
            horiz_phase_a  <= 1'b1;
            horiz_phase_b  <= 1'b0;
        end
        else
        begin
            vert_phase_a   <= (st_q == ST_VERT);
            vert_phase_b   <= (st_q == ST_VERT);
            // dump only with the vertical pulse
            fast_line_dump <= (st_q == ST_VERT) && dump_row;
            horiz_phase_a  <= !h_low;
            horiz_phase_b  <= h_low;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            busy          <= 1'b0;
            right_reverse <= 1'b0;
        end
        else if (st_q == ST_IDLE)
        begin
            busy <= frame_start;
            if (frame_start)
                right_reverse <= dual_mode;
        end
        else
            busy <= (st_q != ST_DONE);
    end

    // ************
    // capture and image stream
    // ************
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            cap_en_q    <= 1'b0;
            cap_last_q  <= 1'b0;
            cap_frame_q <= 1'b0;
            cap_left_q  <= '0;
            cap_right_q <= '0;
        end
        else
        begin
            cap_en_q    <= pix_wrap && row_is_image(row_q) && col_is_kept(pix_q, dual_q);
            cap_last_q  <= (pix_q == col_last);
            cap_frame_q <= (row_q == 11'(ccdrs_pkg::ROW_IMAGE_LAST));
            cap_left_q  <= video_left;
            cap_right_q <= video_right;
        end
    end

    // playback done flag, cleared when a new line starts playing
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            drained_q <= 1'b0;
        else if (rb_last)
            drained_q <= 1'b1;
        else if (cap_en_q && cap_last_q)
            drained_q <= 1'b0;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            pix_valid     <= 1'b0;
            pix_data      <= '0;
            pix_line_end  <= 1'b0;
            pix_frame_end <= 1'b0;
        end
        else if (dual_q)
        begin
            pix_valid     <= rb_valid;
            pix_data      <= rb_data;
            pix_line_end  <= rb_last;
            pix_frame_end <= rb_last && cap_frame_q;
        end
        else
        begin
            // single mode streams the left output
            pix_valid     <= cap_en_q;
            pix_data      <= cap_left_q;
            pix_line_end  <= cap_en_q && cap_last_q;
            pix_frame_end <= cap_en_q && cap_last_q && cap_frame_q;
        end
    end

    ccdrs_line_rebuild #(
        .DW   (DW),
        .HALF (ccdrs_pkg::PIX_ACTIVE_D)
    ) i_rebuild (
        .sys_clk   (sys_clk),
        .rst_b     (rst_b),
        .cap_en    (cap_en_q && dual_q),
        .cap_left  (cap_left_q),
        .cap_right (cap_right_q),
        .cap_last  (cap_last_q),
        .out_valid (rb_valid),
        .out_data  (rb_data),
        .out_last  (rb_last)
    );
endmodule : ccdrs_timing_gen
`default_nettype wire

// [tb/ccd_readout_sequencing_tb.sv]
// testbench: single and dual output line readout
`timescale 1ns/1ps
`default_nettype none
module ccd_readout_sequencing_tb;
    logic sys_clk, rst_b, frame_start, dual_mode, skip_lines, busy, right_reverse;
    logic vert_phase_a, vert_phase_b, horiz_phase_a, horiz_phase_b, fast_line_dump;
    logic pix_valid, pix_line_end, pix_frame_end;
    logic [13:0] video_left, video_right, pix_data;
    logic h_prev = 1'b1;
    int n_mismatch = 0, n_tests = 0, cnt = 0, n_hclk = 0;
    ccdrs_timing_gen #(.HOLD(8)) i_dut (
        .sys_clk        (sys_clk),
        .rst_b          (rst_b),
        .frame_start    (frame_start),
        .dual_mode      (dual_mode),
        .skip_lines     (skip_lines),
        .vert_phase_a   (vert_phase_a),
        .vert_phase_b   (vert_phase_b),
        .horiz_phase_a  (horiz_phase_a),
        .horiz_phase_b  (horiz_phase_b),
        .right_reverse  (right_reverse),
        .fast_line_dump (fast_line_dump),
        .video_left     (video_left),
        .video_right    (video_right),
        .pix_valid      (pix_valid),
        .pix_data       (pix_data),
        .pix_line_end   (pix_line_end),
        .pix_frame_end  (pix_frame_end),
        .busy           (busy)
    );
    ccdrs_sensor_model i_sensor (
        .vert_phase_a  (vert_phase_a),
        .horiz_phase_a (horiz_phase_a),
        .right_reverse (right_reverse),
        .video_left    (video_left),
        .video_right   (video_right)
    );
    // horizontal clocks counted since the last vertical pulse
    always @(posedge sys_clk)
    begin
        h_prev <= horiz_phase_a;
        if (vert_phase_a === 1'b1)
            n_hclk <= 0;
        else if (horiz_phase_a === 1'b1 && h_prev === 1'b0)
            n_hclk <= n_hclk + 1;
    end
    initial
    begin
        sys_clk = 0;
        forever #4 sys_clk = ~sys_clk;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task wrap_up;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up
    // starts a frame, checks the first image line pixel by pixel, counts it
    task automatic run_line(input logic dual, input logic skip, input logic [13:0] exp_first);
        int w;
        dual_mode   = dual;
        skip_lines  = skip;
        frame_start = 1'b1;
        @(posedge sys_clk);
        #1 frame_start = 1'b0;
        w = 0;
        while (pix_valid !== 1'b1 && w < 60000)
        begin
            @(posedge sys_clk);
            #1 w++;
        end
        cnt = 0;
        w   = 0;
        while (w < 12000)
        begin
            if (pix_valid === 1'b1)
            begin
                chk(pix_data, exp_first + 14'(cnt));
                cnt++;
            end
            if (pix_line_end === 1'b1)
                break;
            @(posedge sys_clk);
            #1 w++;
        end
        w = 0;
        while (vert_phase_a !== 1'b1 && w < 2000)
        begin
            @(posedge sys_clk);
            #1 w++;
        end
    endtask : run_line
    task test_single;
        run_line(1'b0, 1'b0, 14'h0018);
        chk(cnt, 32'h0000_0640);
        chk(n_hclk, 32'h0000_066c);
    endtask : test_single
    task test_dual;
        rst_b = 0;
        repeat (12) @(posedge sys_clk);
        #1 rst_b = 1;
        run_line(1'b1, 1'b1, 14'h0014);
        chk(cnt, 32'h0000_0640);
        chk(n_hclk, 32'h0000_0338);
    endtask : test_dual
    initial
    begin
        rst_b = 0;
        frame_start = 0;
        dual_mode = 0;
        skip_lines = 0;
        repeat (12) @(posedge sys_clk);
        #1 rst_b = 1;
        test_single;
        test_dual;
        wrap_up;
    end
    initial
    begin
        repeat (90000) @(posedge sys_clk);
        n_mismatch++;
        wrap_up;
    end
endmodule : ccd_readout_sequencing_tb
bind ccdrs_timing_gen ccdrs_asserts i_chk (
    .sys_clk        (sys_clk),
    .rst_b          (rst_b),
    .frame_start    (frame_start),
    .dual_mode      (dual_mode),
    .skip_lines     (skip_lines),
    .busy           (busy),
    .vert_phase_a   (vert_phase_a),
    .vert_phase_b   (vert_phase_b),
    .horiz_phase_a  (horiz_phase_a),
    .horiz_phase_b  (horiz_phase_b),
    .right_reverse  (right_reverse),
    .fast_line_dump (fast_line_dump),
    .pix_valid      (pix_valid),
    .pix_line_end   (pix_line_end),
    .pix_frame_end  (pix_frame_end)
);
`default_nettype wire

// [tb/ccdrs_asserts.sv]
// checker: timing generator port relations
`timescale 1ns/1ps
`default_nettype none
module ccdrs_asserts (
    // clock and reset
    input wire logic sys_clk, rst_b,
    // control and clocks
    input wire logic frame_start, dual_mode, skip_lines, busy,
    input wire logic vert_phase_a, vert_phase_b, horiz_phase_a, horiz_phase_b,
    input wire logic right_reverse, fast_line_dump,
    // stream
    input wire logic pix_valid, pix_line_end, pix_frame_end
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    a_hold_h_level: assert property (vert_phase_a |-> horiz_phase_a && !horiz_phase_b)
        else $error("horizontal not parked");
    a_hold_delay: assert property ($fell(vert_phase_a) |-> $stable(horiz_phase_a)[*8])
        else $error("horizontal restarted early");
    a_quiet_shift: assert property (pix_valid |-> !vert_phase_a && !fast_line_dump)
        else $error("pulse during shifting");
    a_dump_only_skip: assert property (!skip_lines |-> !fast_line_dump)
        else $error("unexpected line dump");
    a_rev_dual: assert property (busy |-> right_reverse == dual_mode)
        else $error("right direction wrong");
    a_end_valid: assert property (pix_line_end |-> pix_valid)
        else $error("line end without pixel");
    a_frame_in_line: assert property (pix_frame_end |-> pix_line_end)
        else $error("frame end off line end");
    a_start_busy: assert property (frame_start && !busy |=> busy)
        else $error("frame not started");
    a_vert_pair: assert property (vert_phase_a == vert_phase_b)
        else $error("vertical phases apart");
    cover property (pix_line_end && dual_mode);
    cover property (pix_line_end && !dual_mode);
    cover property ($fell(vert_phase_a));
endmodule : ccdrs_asserts
`default_nettype wire

// [tb/ccdrs_sensor_model.sv]
// sensor model: video samples follow the transfer clocks
`timescale 1ns/1ps
`default_nettype none
module ccdrs_sensor_model (
    // clocks
    input  wire logic                            vert_phase_a,
    input  wire logic                            horiz_phase_a,
    input  wire logic                            right_reverse,
    // video
    output logic [ccdrs_pkg::SAMPLE_W-1:0]       video_left,
    output logic [ccdrs_pkg::SAMPLE_W-1:0]       video_right
);
    logic [ccdrs_pkg::SAMPLE_W-1:0] col_q;

    // a vertical transfer loads a fresh row, column count restarts
    always @(posedge vert_phase_a or posedge horiz_phase_a)
        if (vert_phase_a)
            col_q <= 14'h3fff;
        else
            col_q <= col_q + 14'h0001;

    // left output carries the column index
    assign video_left  = col_q;
    // reversed right half carries its image column, so a rebuilt line counts up
    assign video_right = right_reverse ? 14'h0667 - col_q : ~col_q;
endmodule : ccdrs_sensor_model
`default_nettype wire
